// ==== include/fpg_defines.svh ====
`ifndef FPG_DEFINES_SVH
`define FPG_DEFINES_SVH

// Command codes on the management command port (arbitrary)
`define FPG_CODE_Z0A_FWD    8'hD0
`define FPG_CODE_Z0B_FWD    8'hD1
`define FPG_CODE_Z1A_FWD    8'hD2
`define FPG_CODE_Z1B_FWD    8'hD3
`define FPG_CODE_GOOD_MASK  8'hD4
`define FPG_CODE_STATUS     8'hD5
`define FPG_CODE_EVENT      8'hD6

// Fault line indices in the four-line vectors
`define FPG_LINE_Z0A        0
`define FPG_LINE_Z0B        1
`define FPG_LINE_Z1A        2
`define FPG_LINE_Z1B        3
`define FPG_LINES           4

// Field positions
`define FPG_FWD_EN_BIT      0
`define FPG_MASK_CHAN_LSB   0
`define FPG_MASK_CHAN_MSB   7
`define FPG_MASK_WDOG_BIT   8
`define FPG_MASK_W          9
`define FPG_STAT_LEVEL_LSB  0
`define FPG_STAT_DRIVE_LSB  4
`define FPG_STAT_GOOD_BIT   8

// Reset values
`define FPG_FWD_RST         4'h0
`define FPG_MASK_RST        9'h000
`define FPG_EVENT_RST       4'h0
`define FPG_RDATA_RST       16'h0000
`define FPG_DRIVE_RST       2'h0
`define FPG_GOOD_RST        1'b0

`endif

// ==== include/fpg_pkg.sv ====
package fpg_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  code;
    logic [15:0] data;
  } fpg_cmd_t;

  typedef struct packed {
    logic [3:0]  fwd_en;
    logic [8:0]  good_mask;
    logic [3:0]  ext_event;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        cmd_err;
  } fpg_top_state_t;

  typedef struct packed {
    logic [1:0] drive;
  } fpg_zone_state_t;

  typedef struct packed {
    logic good;
  } fpg_good_state_t;

endpackage

// ==== verilog/fpg_zone_fwd.sv ====
`timescale 1ns/10ps
`include "fpg_defines.svh"

module fpg_zone_fwd
  import fpg_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic [CHANNELS-1:0] i_faulted,
  input  wire logic [1:0]          i_fwd_en,
  output logic      [1:0]          o_drive_low
);

  fpg_zone_state_t state;
  fpg_zone_state_t next_state;
  logic            zone_faulted;

  always_comb begin
    zone_faulted = |i_faulted;
    next_state = state;
    // Disabled line is never driven, so other parties keep full control of it
    next_state.drive[0] = i_fwd_en[0] & zone_faulted;
    next_state.drive[1] = i_fwd_en[1] & zone_faulted;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state.drive <= `FPG_DRIVE_RST;
    end else begin
      state <= next_state;
    end
  end

  assign o_drive_low = state.drive;

endmodule // fpg_zone_fwd

// ==== verilog/fpg_good_and.sv ====
`timescale 1ns/10ps
`include "fpg_defines.svh"

module fpg_good_and
  import fpg_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic [CHANNELS-1:0] i_good,
  input  wire logic [CHANNELS-1:0] i_mask,
  input  wire logic [CHANNELS-1:0] i_high_res,
  input  wire logic                i_wdog_mask,
  input  wire logic                i_wdog_expired,
  output logic                     o_good
);

  fpg_good_state_t state;
  fpg_good_state_t next_state;
  logic            all_ok;

  // A term that is not selected reads as true, so it drops out of the AND
  function automatic logic term_ok(input logic status, input logic selected);
    return !selected | status;
  endfunction

  always_comb begin
    all_ok = 1'b1;
    for (int i = 0; i < CHANNELS; i++) begin
      // Odd channels in high resolution carry no valid good status
      all_ok = all_ok & term_ok(i_good[i],
                                i_mask[i] & !((i % 2 == 1) & i_high_res[i]));
    end
    all_ok = all_ok & term_ok(!i_wdog_expired, i_wdog_mask);
    next_state = state;
    next_state.good = all_ok;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state.good <= `FPG_GOOD_RST;
    end else begin
      state <= next_state;
    end
  end

  assign o_good = state.good;

endmodule // fpg_good_and

// ==== verilog/fpg_top.sv ====
// Summary of operation
// - Zone 0 line b driven low on zone fault
// - Zone 1 line a driven low on zone fault
// - Zone 1 line b driven low on zone fault
// - Forward registers: upper fifteen bits read zero
// - Masked channel good statuses are ANDed together
// - Unmasked channels never affect power good
// - Watchdog mask adds not-expired term to AND
// - Watchdog mask clear ignores watchdog state
// - Odd high-resolution channels excluded from power good
// - Mask register upper seven bits read zero
// - Zone 0 line a driven low on zone fault
`timescale 1ns/10ps
`include "fpg_defines.svh"

module fpg_top
  import fpg_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input  wire logic                I_CLK,
  input  wire logic                I_RST_N,
  input  wire fpg_cmd_t            I_CMD,
  output logic      [15:0]         O_RD_DATA,
  output logic                     O_RD_VALID,
  output logic                     O_CMD_ERR,
  input  wire logic [CHANNELS-1:0] I_CHAN_FAULTED,
  input  wire logic [CHANNELS-1:0] I_CHAN_GOOD,
  input  wire logic [CHANNELS-1:0] I_CHAN_HIGH_RES,
  input  wire logic                I_WDOG_EXPIRED,
  input  wire logic [3:0]          I_FAULT_LINE_IN,
  output logic      [3:0]          O_FAULT_LINE_OUT,
  output logic      [3:0]          O_FAULT_LINE_OE,
  output logic                     O_PWRGD
);

  localparam int HALF = CHANNELS / 2;

  fpg_top_state_t state;
  fpg_top_state_t next_state;
  logic [1:0]     zone0_drive;
  logic [1:0]     zone1_drive;
  logic [3:0]     line_drive;
  logic           pwrgd;
  logic           code_known;
  logic [3:0]     ext_seen;
  logic [3:0]     event_clear;
  logic [15:0]    status_word;
  logic [15:0]    rd_value;

  fpg_zone_fwd #(
    .CHANNELS (HALF)
  ) u_zone0 (
    .i_clk       (I_CLK),
    .i_rst_n     (I_RST_N),
    .i_faulted   (I_CHAN_FAULTED[HALF-1:0]),
    .i_fwd_en    ({state.fwd_en[`FPG_LINE_Z0B], state.fwd_en[`FPG_LINE_Z0A]}),
    .o_drive_low (zone0_drive)
  );

  fpg_zone_fwd #(
    .CHANNELS (CHANNELS - HALF)
  ) u_zone1 (
    .i_clk       (I_CLK),
    .i_rst_n     (I_RST_N),
    .i_faulted   (I_CHAN_FAULTED[CHANNELS-1:HALF]),
    .i_fwd_en    ({state.fwd_en[`FPG_LINE_Z1B], state.fwd_en[`FPG_LINE_Z1A]}),
    .o_drive_low (zone1_drive)
  );

  fpg_good_and #(
    .CHANNELS (CHANNELS)
  ) u_good (
    .i_clk          (I_CLK),
    .i_rst_n        (I_RST_N),
    .i_good         (I_CHAN_GOOD),
    .i_mask         (state.good_mask[`FPG_MASK_CHAN_MSB:`FPG_MASK_CHAN_LSB]),
    .i_high_res     (I_CHAN_HIGH_RES),
    .i_wdog_mask    (state.good_mask[`FPG_MASK_WDOG_BIT]),
    .i_wdog_expired (I_WDOG_EXPIRED),
    .o_good         (pwrgd)
  );

  assign line_drive = {zone1_drive, zone0_drive};

  always_comb begin
    code_known = 1'b0;
    unique case (I_CMD.code)
      `FPG_CODE_Z0A_FWD,
      `FPG_CODE_Z0B_FWD,
      `FPG_CODE_Z1A_FWD,
      `FPG_CODE_Z1B_FWD,
      `FPG_CODE_GOOD_MASK,
      `FPG_CODE_STATUS,
      `FPG_CODE_EVENT: code_known = 1'b1;
      default: code_known = 1'b0;
    endcase
  end

  // A low line that this end is not pulling was asserted by another party
  assign ext_seen = ~I_FAULT_LINE_IN & ~line_drive;

  assign status_word = {7'h00,
                        pwrgd,
                        line_drive,
                        I_FAULT_LINE_IN};

  always_comb begin
    rd_value = `FPG_RDATA_RST;
    unique case (I_CMD.code)
      `FPG_CODE_Z0A_FWD: rd_value = {15'h0000, state.fwd_en[`FPG_LINE_Z0A]};
      `FPG_CODE_Z0B_FWD: rd_value = {15'h0000, state.fwd_en[`FPG_LINE_Z0B]};
      `FPG_CODE_Z1A_FWD: rd_value = {15'h0000, state.fwd_en[`FPG_LINE_Z1A]};
      `FPG_CODE_Z1B_FWD: rd_value = {15'h0000, state.fwd_en[`FPG_LINE_Z1B]};
      `FPG_CODE_GOOD_MASK: rd_value = {7'h00, state.good_mask};
      `FPG_CODE_STATUS: rd_value = status_word;
      `FPG_CODE_EVENT: rd_value = {12'h000, state.ext_event};
      default: rd_value = `FPG_RDATA_RST;
    endcase
  end

  always_comb begin
    next_state = state;
    event_clear = 4'h0;
    if (I_CMD.wr) begin
      unique case (I_CMD.code)
        // Only the enable bit is stored; the other fifteen data bits are dropped
        `FPG_CODE_Z0A_FWD: begin
          next_state.fwd_en[`FPG_LINE_Z0A] = I_CMD.data[`FPG_FWD_EN_BIT];
        end
        `FPG_CODE_Z0B_FWD: begin
          next_state.fwd_en[`FPG_LINE_Z0B] = I_CMD.data[`FPG_FWD_EN_BIT];
        end
        `FPG_CODE_Z1A_FWD: begin
          next_state.fwd_en[`FPG_LINE_Z1A] = I_CMD.data[`FPG_FWD_EN_BIT];
        end
        `FPG_CODE_Z1B_FWD: begin
          next_state.fwd_en[`FPG_LINE_Z1B] = I_CMD.data[`FPG_FWD_EN_BIT];
        end
        `FPG_CODE_GOOD_MASK: begin
          next_state.good_mask = I_CMD.data[`FPG_MASK_W-1:0];
        end
        `FPG_CODE_EVENT: begin
          event_clear = I_CMD.data[3:0];
        end
        default: begin
          event_clear = 4'h0;
        end
      endcase
    end
    // Set beats clear so an assertion in the clearing cycle is kept
    next_state.ext_event = (state.ext_event & ~event_clear) | ext_seen;
    next_state.rd_valid = I_CMD.rd;
    next_state.cmd_err = (I_CMD.rd | I_CMD.wr) & !code_known;
    if (I_CMD.rd) begin
      next_state.rd_data = rd_value;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state.fwd_en    <= `FPG_FWD_RST;
      state.good_mask <= `FPG_MASK_RST;
      state.ext_event <= `FPG_EVENT_RST;
      state.rd_data   <= `FPG_RDATA_RST;
      state.rd_valid  <= 1'b0;
      state.cmd_err   <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // Open-drain: level is always low, only the enable toggles
  assign O_FAULT_LINE_OUT = 4'h0;
  assign O_FAULT_LINE_OE  = line_drive;
  assign O_PWRGD          = pwrgd;
  assign O_RD_DATA        = state.rd_data;
  assign O_RD_VALID       = state.rd_valid;
  assign O_CMD_ERR        = state.cmd_err;

endmodule // fpg_top

// ==== testbench/fpg_peer.sv ====
`timescale 1ns/10ps
module fpg_peer (
  input  wire logic [3:0] i_oe,
  input  wire logic [3:0] i_pull,
  output logic      [3:0] o_line
);
  // Pull-ups: a released line reads high, any puller wins
  assign o_line = ~(i_oe | i_pull);
endmodule // fpg_peer

// ==== testbench/fpg_top_asserts.sv ====
`timescale 1ns/10ps
`include "fpg_defines.svh"
module fpg_top_asserts
  import fpg_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input wire logic                I_CLK,
  input wire logic                I_RST_N,
  input wire fpg_cmd_t            I_CMD,
  input wire logic [15:0]         O_RD_DATA,
  input wire logic [CHANNELS-1:0] I_CHAN_FAULTED,
  input wire logic [CHANNELS-1:0] I_CHAN_GOOD,
  input wire logic [CHANNELS-1:0] I_CHAN_HIGH_RES,
  input wire logic                I_WDOG_EXPIRED,
  input wire logic [3:0]          O_FAULT_LINE_OE,
  input wire logic                O_PWRGD
);
  logic [8:0] mask;
  logic [3:0] en;
  logic [3:0] oe_exp;
  logic       up;
  logic       chan_ok;
  logic       good_exp;
  logic       wd_kill;
  logic       mask_empty;
  // Shadow of the config, so outputs are judged from the command stream
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mask <= 9'h000;
      en <= 4'h0;
      up <= 1'b0;
    end else begin
      up <= 1'b1;
      if (I_CMD.wr && I_CMD.code == `FPG_CODE_GOOD_MASK) mask <= I_CMD.data[8:0];
      for (int k = 0; k < 4; k++)
        if (I_CMD.wr && I_CMD.code == 8'(`FPG_CODE_Z0A_FWD + k)) en[k] <= I_CMD.data[0];
    end
  end
  always_comb begin
    chan_ok = 1'b1;
    for (int k = 0; k < CHANNELS; k++)
      if (mask[k] && !(k[0] && I_CHAN_HIGH_RES[k])) chan_ok &= I_CHAN_GOOD[k];
  end
  assign wd_kill = mask[8] & I_WDOG_EXPIRED;
  assign good_exp = chan_ok & ~wd_kill;
  assign mask_empty = (mask == 9'h000);
  assign oe_exp = en & {{2{|I_CHAN_FAULTED[7:4]}}, {2{|I_CHAN_FAULTED[3:0]}}};
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence fwd_read;
    I_CMD.rd && I_CMD.code[7:2] == 6'h34;
  endsequence
  sequence mask_read;
    I_CMD.rd && I_CMD.code == `FPG_CODE_GOOD_MASK;
  endsequence
  a_z0a_drive: assert property (up |-> O_FAULT_LINE_OE[0] == $past(oe_exp[0]))
    else $error("zone0 line a drive wrong");
  a_z0b_drive: assert property (up |-> O_FAULT_LINE_OE[1] == $past(oe_exp[1]))
    else $error("zone0 line b drive wrong");
  a_z1a_drive: assert property (up |-> O_FAULT_LINE_OE[2] == $past(oe_exp[2]))
    else $error("zone1 line a drive wrong");
  a_z1b_drive: assert property (up |-> O_FAULT_LINE_OE[3] == $past(oe_exp[3]))
    else $error("zone1 line b drive wrong");
  a_fwd_rsvd: assert property (fwd_read |=> O_RD_DATA[15:1] == 15'h0000)
    else $error("forward upper bits not zero");
  a_mask_rsvd: assert property (mask_read |=> O_RD_DATA == {7'h00, $past(mask)})
    else $error("mask readback wrong");
  a_good_and: assert property (up |-> O_PWRGD == $past(good_exp))
    else $error("power good mismatch");
  a_wdog_term: assert property (up && $past(wd_kill) |-> !O_PWRGD)
    else $error("expired watchdog ignored");
  a_wdog_free: assert property (up && $past(chan_ok) && !$past(mask[8]) |-> O_PWRGD)
    else $error("watchdog leaked into power good");
  a_empty_good: assert property (up && $past(mask_empty) |-> O_PWRGD)
    else $error("empty mask not good");
endmodule // fpg_top_asserts
bind fpg_top fpg_top_asserts #(.CHANNELS(CHANNELS)) fpg_top_asserts_i (.I_CLK, .I_RST_N,
  .I_CMD, .O_RD_DATA, .I_CHAN_FAULTED, .I_CHAN_GOOD, .I_CHAN_HIGH_RES, .I_WDOG_EXPIRED,
  .O_FAULT_LINE_OE, .O_PWRGD);

// ==== testbench/tb_fpg_top.sv ====
`timescale 1ns/10ps
`include "fpg_defines.svh"
module tb_fpg_top
  import fpg_pkg::*;
();
  typedef struct packed {logic [8:0] m; logic [7:0] g, h; logic w, p;} fpg_row_t;
  fpg_row_t   rows [10] = '{'{9'h0FF, 8'hFF, 8'h00, 1'b1, 1'b1},
    '{9'h0FF, 8'hFE, 8'h00, 1'b0, 1'b0}, '{9'h0FE, 8'hFE, 8'h00, 1'b0, 1'b1},
    '{9'h0FF, 8'hFD, 8'h02, 1'b0, 1'b1}, '{9'h0FF, 8'hFE, 8'h01, 1'b0, 1'b0},
    '{9'h100, 8'h00, 8'h00, 1'b1, 1'b0}, '{9'h100, 8'h00, 8'h00, 1'b0, 1'b1},
    '{9'h000, 8'h00, 8'h00, 1'b1, 1'b1}, '{9'h180, 8'h7F, 8'h00, 1'b0, 1'b0},
    '{9'h1AA, 8'h55, 8'hAA, 1'b0, 1'b1}};
  logic       clk, rst_n, wdog, rd_valid, cmd_err, pwrgd;
  fpg_cmd_t   cmd;
  logic [7:0] flt, good, hres;
  logic [3:0] pull, line_in, oe, lvl;
  logic [15:0] rd_data;
  int         failures = 0;
  int         samples_checked = 0;
  fpg_top #(.CHANNELS(8)) fpg_top_i (.I_CLK(clk), .I_RST_N(rst_n), .I_CMD(cmd),
    .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid), .O_CMD_ERR(cmd_err), .I_CHAN_FAULTED(flt),
    .I_CHAN_GOOD(good), .I_CHAN_HIGH_RES(hres), .I_WDOG_EXPIRED(wdog),
    .I_FAULT_LINE_IN(line_in), .O_FAULT_LINE_OUT(lvl), .O_FAULT_LINE_OE(oe), .O_PWRGD(pwrgd));
  fpg_peer fpg_peer_i (.i_oe(oe), .i_pull(pull), .o_line(line_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // Strobe lowered a step after the edge, so back-to-back calls never collide
  task automatic send(input logic w, input logic r, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    #1 cmd = '{w, r, c, d};
    @(posedge clk);
    #1 cmd = '0;
  endtask
  task automatic read(input logic [7:0] c, input logic [15:0] want);
    send(1'b0, 1'b1, c, 16'h0000);
    check(rd_valid ? rd_data : 16'hDEAD, want);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict;
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
  initial begin
    {cmd, flt, good, hres, wdog, pull} = '0;
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    #1 check({oe, 11'h000, pwrgd}, 16'h0000);
    rst_n = 1'b1;
    settle();
    check({15'h0000, pwrgd}, 16'h0001);
    foreach (rows[k]) begin
      {good, hres, wdog} = {rows[k].g, rows[k].h, rows[k].w};
      send(1'b1, 1'b0, `FPG_CODE_GOOD_MASK, {7'h00, rows[k].m});
      settle();
      check({15'h0000, pwrgd}, {15'h0000, rows[k].p});
    end
    for (int i = 0; i < 4; i++) begin
      send(1'b1, 1'b0, 8'(`FPG_CODE_Z0A_FWD + i), 16'hFFFF);
      read(8'(`FPG_CODE_Z0A_FWD + i), 16'h0001);
      flt = (i < 2) ? 8'h40 : 8'h04;
      settle();
      check({12'h000, oe}, 16'h0000);
      flt = (i < 2) ? 8'h08 : 8'h80;
      settle();
      check({8'h00, lvl, oe}, 16'(1 << i));
      send(1'b1, 1'b0, 8'(`FPG_CODE_Z0A_FWD + i), 16'h0000);
      settle();
      check({12'h000, oe}, 16'h0000);
      flt = '0;
    end
    // A peer pulling a line must not look like our own drive
    pull = 4'h4;
    send(1'b0, 1'b1, `FPG_CODE_STATUS, 16'h0000);
    check(rd_data, 16'h010B);
    read(`FPG_CODE_EVENT, 16'h0004);
    // Clear while the peer still pulls: the new assertion must survive
    send(1'b1, 1'b0, `FPG_CODE_EVENT, 16'h000F);
    read(`FPG_CODE_EVENT, 16'h0004);
    pull = 4'h0;
    send(1'b1, 1'b0, `FPG_CODE_EVENT, 16'h000F);
    read(`FPG_CODE_EVENT, 16'h0000);
    send(1'b1, 1'b0, `FPG_CODE_GOOD_MASK, 16'hFFFF);
    read(`FPG_CODE_GOOD_MASK, 16'h01FF);
    send(1'b1, 1'b1, `FPG_CODE_GOOD_MASK, 16'h0000);
    check(rd_data, 16'h01FF);
    send(1'b0, 1'b1, 8'h00, 16'h0000);
    check(rd_data | {15'h0000, cmd_err}, 16'h0001);
    rst_n = 1'b0;
    @(posedge clk);
    #1 check({oe, 11'h000, pwrgd}, 16'h0000);
    rst_n = 1'b1;
    read(`FPG_CODE_GOOD_MASK, 16'h0000);
    check({14'h0000, cmd_err, pwrgd}, 16'h0001);
    give_verdict();
  end
endmodule // tb_fpg_top
